// file: rtl/upst_consts.vh
/*
 Constants for the Phy_done_strobe and transmit control block: power state
 codes, de-emphasis codes, AXI4-Lite register map and timing counts.
 Assumes a 25 MHz core clock that is also the parallel interface clock.
*/
// Overview of operation
// [R1] Completion strobe marks end of power change, rate change or detection.
// [R2] Strobe around P3 with stopped clock is asynchronous; MAC samples it so.
// [R3] MAC raises low-frequency pattern request only while sending CP7 or CP8.
// [R4] Request high: alternate runs of 50 to 250 ones and zeros.
// [R5] New de-emphasis select takes effect within 128 ns.
// [R6] De-emphasis 00 is -6 dB, 01 -3.5 dB, 10 none, 11 reserved.
// [R7] Power state 00 P0, 01 P1, 10 P2, 11 P3 lowest power.
// [R8] Outside P3 case, strobe is one clock pulse per completed operation.
`ifndef UPST_CONSTS_VH
`define UPST_CONSTS_VH

// ==================================================
// Power states
`define UPST_PWR_P0        2'h0
`define UPST_PWR_P1        2'h1
`define UPST_PWR_P2        2'h2
`define UPST_PWR_P3        2'h3

// ==================================================
// De-emphasis codes
`define UPST_DEEMPH_6DB    2'h0
`define UPST_DEEMPH_3P5DB  2'h1
`define UPST_DEEMPH_NONE   2'h2
`define UPST_DEEMPH_RSVD   2'h3

// ==================================================
// Register byte offsets
`define UPST_REG_CTRL      4'h0
`define UPST_REG_STATUS    4'h4
`define UPST_REG_COUNT     4'h8

// ==================================================
// Control register fields
`define UPST_CTRL_PWR_LSB  0
`define UPST_CTRL_RATE     2
`define UPST_CTRL_DET      3
`define UPST_CTRL_RESET    32'h0000_0000

// ==================================================
// Timing
`define UPST_CLK_MHZ       25
`define UPST_DEEMPH_NS     128
// Longest time rounds down: 128 ns * 25 MHz / 1000 = 3 cycles
`define UPST_DEEMPH_CYC    ((`UPST_DEEMPH_NS * `UPST_CLK_MHZ) / 1000)
`define UPST_RUN_DEF       100
`define UPST_RUN_MIN       50
`define UPST_RUN_MAX       250
`define UPST_OP_CYC        8

`endif

// file: rtl/upst_phy_ctrl.v
/*
 Phy_done_strobe strobe and transmit control, AXI4-Lite register slave.
 Assumes one clock, inputs synchronous to it, MAC keeps its own rules.
*/
`include "upst_consts.vh"

module upst_phy_ctrl #(
   parameter RUN_LEN = `UPST_RUN_DEF,
   parameter OP_CYC  = `UPST_OP_CYC
) (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // AXI4-Lite write address and data
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // AXI4-Lite read
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   input  wire [3:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // MAC side pins
   input  wire        tx_low_freq_pattern_req,
   input  wire [1:0]  tx_deemphasis_select,
   input  wire [9:0]  txData,
   input  wire        pclkRunning,
   // PHY outputs
   output reg         phy_done_strobe,
   output reg  [9:0]  txSymbol,
   output reg  [1:0]  txDeemphApplied,
   output reg  [1:0]  phyPowerState
);

   localparam ST_IDLE = 2'h0;
   localparam ST_BUSY = 2'h1;
   localparam ST_DONE = 2'h2;

   reg [1:0]  state_r;
   reg [7:0]  opCnt_r;
   reg [1:0]  pwrReq_r;
   reg        p3Async_r;
   reg [7:0]  runCnt_r;
   reg        runLevel_r;
   reg [1:0]  dmCnt_r;
   reg [15:0] doneCnt_r;
   reg        awHeld_r;
   reg        wHeld_r;
   reg [3:0]  awAddr_r;
   reg [31:0] wData_r;
   reg        opStart;
   reg [31:0] rdVal;

   // ==================================================
   // Register write path
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         awAddr_r      <= 4'h0;
         wData_r       <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r      <= 1'b1;
            awAddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r      <= 1'b1;
            wData_r      <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            // Busy operation refuses new control writes
            if (awAddr_r == `UPST_REG_CTRL)
               s_axi_bresp <= (state_r == ST_IDLE) ? 2'h0 : 2'h2;
            else
               s_axi_bresp <= 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control write launches an operation
   always @* begin
      opStart = awHeld_r && wHeld_r && !s_axi_bvalid &&
                (awAddr_r == `UPST_REG_CTRL) && (state_r == ST_IDLE);
   end

   // ==================================================
   // Operation sequencer and completion strobe
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r         <= ST_IDLE;
         opCnt_r         <= 8'h00;
         pwrReq_r        <= `UPST_PWR_P0;
         phyPowerState   <= `UPST_PWR_P0;
         phy_done_strobe <= 1'b0;
         p3Async_r       <= 1'b0;
         doneCnt_r       <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (p3Async_r && pclkRunning) begin
                  // Async level released once clock is back
                  phy_done_strobe <= 1'b0;
                  p3Async_r       <= 1'b0;
               end else if (!p3Async_r) begin
                  phy_done_strobe <= 1'b0;
               end
               if (opStart) begin
                  // [R7] power state field
                  pwrReq_r <= wData_r[`UPST_CTRL_PWR_LSB+1:`UPST_CTRL_PWR_LSB];
                  opCnt_r  <= OP_CYC[7:0];
                  state_r  <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (opCnt_r == 8'h01)
                  state_r <= ST_DONE;
               opCnt_r <= opCnt_r - 8'h01;
            end
            default: begin
               // [R1] completion announced
               phyPowerState   <= pwrReq_r;
               phy_done_strobe <= 1'b1;
               doneCnt_r       <= doneCnt_r + 16'h0001;
               // [R2] held level when clock stopped around P3
               p3Async_r <= !pclkRunning &&
                  ((pwrReq_r == `UPST_PWR_P3) ||
                   (phyPowerState == `UPST_PWR_P3));
               // [R8] otherwise a one cycle pulse
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==================================================
   // Register read path, unmapped answers SLVERR
   always @* begin
      if (s_axi_araddr == `UPST_REG_CTRL)
         rdVal = {30'h0, pwrReq_r};
      else if (s_axi_araddr == `UPST_REG_STATUS)
         rdVal = {26'h0, txDeemphApplied, p3Async_r, state_r != ST_IDLE,
                  phyPowerState};
      else if (s_axi_araddr == `UPST_REG_COUNT)
         rdVal = {16'h0, doneCnt_r};
      else
         rdVal = 32'h0000_0000;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdVal;
         s_axi_rresp   <= (s_axi_araddr == `UPST_REG_CTRL ||
                           s_axi_araddr == `UPST_REG_STATUS ||
                           s_axi_araddr == `UPST_REG_COUNT) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==================================================
   // Transmit path: low-frequency pattern and de-emphasis
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txSymbol        <= 10'h000;
         runCnt_r        <= 8'h00;
         runLevel_r      <= 1'b1;
         txDeemphApplied <= `UPST_DEEMPH_6DB;
         dmCnt_r         <= 2'h0;
      end else begin
         if (tx_low_freq_pattern_req) begin
            // [R4] runs of ones then zeros, data ignored
            txSymbol <= {10{runLevel_r}};
            if (runCnt_r >= RUN_LEN[7:0] - 8'h01) begin
               runCnt_r   <= 8'h00;
               runLevel_r <= !runLevel_r;
            end else begin
               runCnt_r <= runCnt_r + 8'h01;
            end
         end else begin
            txSymbol   <= txData;
            runCnt_r   <= 8'h00;
            runLevel_r <= 1'b1;
         end
         // [R5] apply new select within bound
         // [R6] reserved code keeps last setting
         if (tx_deemphasis_select == txDeemphApplied ||
             tx_deemphasis_select == `UPST_DEEMPH_RSVD) begin
            dmCnt_r <= 2'h0;
         end else if (dmCnt_r >= 2'h1) begin
            txDeemphApplied <= tx_deemphasis_select;
            dmCnt_r         <= 2'h0;
         end else begin
            dmCnt_r <= dmCnt_r + 2'h1;
         end
      end
   end

endmodule // upst_phy_ctrl

// file: verification/upst_phy_ctrl_chk.sv
/* Port checker for upst_phy_ctrl: strobe, pattern, de-emphasis.
   Assumes binding into upst_phy_ctrl; one clock, async reset. */
// ========================================
// Checker
module upst_phy_ctrl_chk #(
   parameter RUN_LEN = 100,
   parameter OP_CYC  = 8
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // Register writes
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   // Pins
   input wire logic        tx_low_freq_pattern_req,
   input wire logic [1:0]  tx_deemphasis_select,
   input wire logic        pclkRunning,
   input wire logic        phy_done_strobe,
   input wire logic [9:0]  txSymbol,
   input wire logic [1:0]  txDeemphApplied,
   input wire logic [1:0]  phyPowerState
);
   timeunit 1ns;
   timeprecision 1ps;
   // Antecedent is seen one edge after bvalid rises, strobe OP_CYC+1 later
   localparam int DONE_DLY = OP_CYC + 1;
   logic [1:0] pend_r;
   logic [1:0] reqPwr_r;
   logic [8:0] runCnt_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Refused writes never reach the state model
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_r   <= 2'h0;
         reqPwr_r <= 2'h0;
         runCnt_r <= 9'h001;
      end else begin
         if (s_axi_wvalid && s_axi_wready)
            pend_r <= s_axi_wdata[1:0];
         if (s_axi_bvalid && s_axi_bresp == 2'h0)
            reqPwr_r <= pend_r;
         if (tx_low_freq_pattern_req && $stable(txSymbol))
            runCnt_r <= runCnt_r + 9'h001;
         else
            runCnt_r <= 9'h001;
      end
   end
   sequence ctrlOk;
      $rose(s_axi_bvalid) && s_axi_bresp == 2'h0;
   endsequence
   sequence doneRise;
      $rose(phy_done_strobe);
   endsequence
   a_done_timing: assert property (ctrlOk |-> ##DONE_DLY doneRise)
      else $error("completion strobe late or missing");
   a_power_update: assert property (doneRise |-> phyPowerState == reqPwr_r)
      else $error("power state wrong at completion");
   a_strobe_pulse: assert property (phy_done_strobe && pclkRunning |=> !phy_done_strobe)
      else $error("strobe wider than one cycle");
   a_p3_hold: assert property (phy_done_strobe && !pclkRunning && phyPowerState == 2'h3 |=> phy_done_strobe)
      else $error("strobe dropped with clock stopped");
   a_pattern_only: assert property (tx_low_freq_pattern_req ##1 tx_low_freq_pattern_req |-> txSymbol == 10'h3FF || txSymbol == 10'h000)
      else $error("pattern symbol not all ones or zeros");
   a_run_bound: assert property (runCnt_r <= RUN_LEN)
      else $error("pattern run too long");
   a_deemph_apply: assert property ((tx_deemphasis_select != 2'h3 && $stable(tx_deemphasis_select)) [*3] |-> txDeemphApplied == tx_deemphasis_select)
      else $error("de-emphasis not applied in time");
   a_rsvd_never: assert property (txDeemphApplied != 2'h3)
      else $error("reserved de-emphasis applied");
endmodule // upst_phy_ctrl_chk

bind upst_phy_ctrl upst_phy_ctrl_chk #(.RUN_LEN(RUN_LEN), .OP_CYC(OP_CYC))
   u_chk (.*);

// file: verification/upst_mac_model.sv
/* MAC side model: compliance request, de-emphasis select, symbols.
   Assumes bench commands on the same clock. */
// ========================================
// Model
module upst_mac_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Bench commands
   input  wire logic       cpOn,
   input  wire logic [1:0] deCmd,
   // Pins toward the PHY
   output logic            tx_low_freq_pattern_req,
   output logic [1:0]      tx_deemphasis_select,
   output logic [9:0]      txData
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_low_freq_pattern_req <= 1'b0;
         tx_deemphasis_select    <= 2'h0;
         txData                  <= 10'h000;
      end else begin
         tx_low_freq_pattern_req <= cpOn;
         tx_deemphasis_select <= deCmd;
         // Changes every cycle so a stale symbol shows
         txData <= txData + 10'h001;
      end
   end
endmodule // upst_mac_model

// file: verification/tb_top.sv
/* Self-checking bench for upst_phy_ctrl over AXI4-Lite.
   Assumes the MAC model and the bound checker. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RUN = 50;
   // ========================================
   // Signals
   logic clk, arst_n, pclkRunning, cpOn, phy_done_strobe;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, tx_low_freq_pattern_req;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_deemphasis_select, deCmd;
   logic [1:0]  txDeemphApplied, phyPowerState;
   logic [9:0]  txData, txSymbol;
   logic [1:0]  pw [3] = '{2'h1, 2'h2, 2'h0};
   int          err_total, compares, cyc, n;
   upst_phy_ctrl #(.RUN_LEN(RUN)) uut (.*);
   upst_mac_model mac (.*);
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   // ========================================
   // Tasks
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      bit pa, pd;
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      pa = 1;
      pd = 1;
      while (pa || pd) begin
         @(posedge clk);
         if (pa && s_axi_awready === 1'b1) begin
            pa = 0;
            s_axi_awvalid <= 0;
         end
         if (pd && s_axi_wready === 1'b1) begin
            pd = 0;
            s_axi_wvalid <= 0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      s_axi_bready <= 0;
      chk(s_axi_bresp, r);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= a;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
   endtask
   task waitDone;
      do @(posedge clk); while (phy_done_strobe !== 1'b1);
   endtask
   task complete_run;
      $display("Compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         complete_run;
      end
   end
   // ========================================
   // Sequence
   initial begin
      {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, cpOn, deCmd} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hF;
      pclkRunning = 1;
      repeat (16) @(posedge clk);
      arst_n <= 1;
      rd(4'h4, 32'h0, 2'h0);
      for (int i = 0; i < 4; i++) begin
         deCmd <= i[1:0];
         repeat (6) @(posedge clk);
         chk(txDeemphApplied, (i == 3) ? 2 : i);
      end
      deCmd <= 2'h1;
      repeat (6) @(posedge clk);
      foreach (pw[k]) begin
         wr(4'h0, {30'h0, pw[k]}, 2'h0);
         if (k == 0) wr(4'h0, 32'h2, 2'h2);
         waitDone;
         @(posedge clk);
         chk(phy_done_strobe, 0);
         chk(phyPowerState, pw[k]);
         rd(4'h4, {26'h0, 2'h1, 2'h0, pw[k]}, 2'h0);
      end
      rd(4'h8, 32'h3, 2'h0);
      pclkRunning <= 0;
      wr(4'h0, 32'h3, 2'h0);
      waitDone;
      repeat (4) @(posedge clk);
      chk(phy_done_strobe, 1);
      pclkRunning <= 1;
      repeat (3) @(posedge clk);
      chk(phy_done_strobe, 0);
      rd(4'h4, 32'h13, 2'h0);
      rd(4'hC, 32'h0, 2'h2);
      wr(4'h4, 32'h0, 2'h2);
      cpOn <= 1;
      do @(posedge clk); while (txSymbol !== 10'h000);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (txSymbol === 10'h000);
      chk(n, RUN);
      chk(txSymbol, 10'h3FF);
      cpOn <= 0;
      complete_run;
   end
endmodule // tb_top
